/* verilog/fault_bank_pkg.sv */
// Purpose: shared constants and carriers of the input fault status bank
// Assumes: 8-bit registers on an 8-bit address space of the control port
// Notes: all offsets, field positions and reset values live here
package fault_bank_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] CHANNEL4_FAULT_LIVE_ADDR = 8'h31;
    localparam logic [7:0] INPUT_OVERVOLTAGE_LIVE_ADDR = 8'h35;
    localparam logic [7:0] BIAS_FAULT_LIVE_ADDR = 8'h37;
    localparam logic [7:0] BIAS_OVERVOLTAGE_CONFIG_ADDR = 8'h55;

    // ************************************************************
    // reset values and fields
    // ************************************************************
    localparam logic [7:0] LIVE_RESET = 8'h00;
    localparam logic [7:0] BIAS_OVERVOLTAGE_CONFIG_RESET = 8'h40;
    localparam int THRESHOLD_MSB = 7;
    localparam int THRESHOLD_LSB = 5;
    localparam logic [2:0] THRESHOLD_RESET = 3'h2;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ************************************************************
    // threshold margins in mV
    // ************************************************************
    localparam logic [7:0] MARGIN_CODE0_MV = 8'h00;
    localparam logic [7:0] MARGIN_CODE1_MV = 8'h0a;
    localparam logic [7:0] MARGIN_CODE2_MV = 8'h28;
    localparam logic [7:0] MARGIN_STEP_MV = 8'h1e;
    localparam logic [7:0] MARGIN_CODE7_MV = 8'hbe;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic open_input;
        logic pair_short;
        logic pos_ground_short;
        logic neg_ground_short;
        logic pos_bias_short;
        logic neg_bias_short;
        logic pos_battery_short;
        logic neg_battery_short;
    } ch4_fault_t;

    typedef struct packed {
        logic ch1_pos;
        logic ch2_pos;
        logic ch3_pos;
        logic ch4_pos;
    } input_ov_t;

    typedef struct packed {
        logic high_current;
        logic low_current;
        logic overvoltage;
    } bias_fault_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } reg_req_t;

endpackage

/* verilog/level_sync.sv */
// Purpose: two-flop synchroniser for detector levels
// Assumes: inputs are asynchronous to CLK
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module level_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule // level_sync

/* verilog/threshold_margin.sv */
// Purpose: maps the bias overvoltage threshold code to a margin in mV
// Assumes: code is a registered field
// Notes: result is combinational; caller registers it
`timescale 1ns/1ps
module threshold_margin
    import fault_bank_pkg::*;
(
    // code in, margin out
    input wire logic [2:0] code,
    output logic [7:0] margin_mv
);
    logic [7:0] steps;

    // codes 3..6 step from code 2
    assign steps = {5'h00, code} - 8'h02;

    always_comb begin
        case (code)
            3'h0: margin_mv = MARGIN_CODE0_MV;
            3'h1: margin_mv = MARGIN_CODE1_MV;
            3'h2: margin_mv = MARGIN_CODE2_MV;
            3'h3, 3'h4, 3'h5, 3'h6: margin_mv = 8'(MARGIN_CODE2_MV + 8'(steps * MARGIN_STEP_MV));
            3'h7: margin_mv = MARGIN_CODE7_MV;
            default: margin_mv = MARGIN_CODE2_MV;
        endcase
    end
endmodule // threshold_margin

/* verilog/mic_input_fault_status_bank.sv */
// Purpose: live fault status bank and bias overvoltage threshold config
// Assumes: detector outputs are asynchronous levels; control port gives byte reads/writes
// Notes: live bits follow detectors after two clocks
`timescale 1ns/1ps
module mic_input_fault_status_bank
    import fault_bank_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // control port register access
    input wire fault_bank_pkg::reg_req_t REG_REQ,
    output logic [7:0] REG_RDATA,
    output logic REG_RVALID,
    // fault detector levels
    input wire fault_bank_pkg::ch4_fault_t CH4_FAULT,
    input wire fault_bank_pkg::input_ov_t INPUT_OV_FAULT,
    input wire fault_bank_pkg::bias_fault_t BIAS_FAULT,
    // to the bias overvoltage comparator
    output logic [2:0] BIAS_OV_THRESHOLD,
    output logic [7:0] BIAS_OV_MARGIN_MV
);
    import fault_bank_pkg::*;

    // ************************************************************
    // detector synchronisation
    // ************************************************************
    ch4_fault_t channel4_fault_live;
    input_ov_t ov_live;
    bias_fault_t bias_live;

    level_sync #(.WIDTH(8)) ch4_sync (
        .clk(CLK),
        .rst(RST),
        .async_in(CH4_FAULT),
        .sync_out(channel4_fault_live)
    );

    level_sync #(.WIDTH(4)) ov_sync (
        .clk(CLK),
        .rst(RST),
        .async_in(INPUT_OV_FAULT),
        .sync_out(ov_live)
    );

    level_sync #(.WIDTH(3)) bias_sync (
        .clk(CLK),
        .rst(RST),
        .async_in(BIAS_FAULT),
        .sync_out(bias_live)
    );

    // ************************************************************
    // register images
    // ************************************************************
    logic [7:0] ch4_image;
    logic [7:0] ov_image;
    logic [7:0] bias_image;
    logic [7:0] config_image;
    logic [2:0] threshold_r;
    logic [2:0] threshold_nxt;

    assign ch4_image = {channel4_fault_live.open_input, channel4_fault_live.pair_short,
                        channel4_fault_live.pos_ground_short, channel4_fault_live.neg_ground_short,
                        channel4_fault_live.pos_bias_short, channel4_fault_live.neg_bias_short,
                        channel4_fault_live.pos_battery_short, channel4_fault_live.neg_battery_short};

    assign ov_image = {ov_live.ch1_pos, ov_live.ch2_pos, ov_live.ch3_pos, ov_live.ch4_pos, 4'h0};

    // high current at bit 7, low current at bit 6, overvoltage at bit 5, rest zero
    assign bias_image = {bias_live.high_current, bias_live.low_current, bias_live.overvoltage, 5'h00};

    assign config_image = {threshold_r, 5'h00};

    // ************************************************************
    // address decode
    // ************************************************************
    logic hit_ch4;
    logic hit_ov;
    logic hit_bias;
    logic hit_config;
    logic cfg_write;
    logic [7:0] rd_mux;

    assign hit_ch4 = (REG_REQ.addr == CHANNEL4_FAULT_LIVE_ADDR);
    assign hit_ov = (REG_REQ.addr == INPUT_OVERVOLTAGE_LIVE_ADDR);
    assign hit_bias = (REG_REQ.addr == BIAS_FAULT_LIVE_ADDR);
    assign hit_config = (REG_REQ.addr == BIAS_OVERVOLTAGE_CONFIG_ADDR);

    assign cfg_write = REG_REQ.wr & hit_config;

    assign threshold_nxt = cfg_write ? REG_REQ.wdata[THRESHOLD_MSB:THRESHOLD_LSB] : threshold_r;

    assign rd_mux = hit_ch4 ? ch4_image :
                    hit_ov ? ov_image :
                    hit_bias ? bias_image :
                    hit_config ? config_image : UNMAPPED_READ;

    // ************************************************************
    // configuration and read data
    // ************************************************************
    logic [7:0] rdata_r;
    logic rvalid_r;
    logic [7:0] margin_mv;
    logic [7:0] margin_r;

    always_ff @(posedge CLK) begin
        if (RST) begin
            threshold_r <= THRESHOLD_RESET;
        end else begin
            threshold_r <= threshold_nxt;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            rdata_r <= LIVE_RESET;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r <= REG_REQ.rd ? rd_mux : rdata_r;
            rvalid_r <= REG_REQ.rd;
        end
    end

    // ************************************************************
    // threshold to comparator
    // ************************************************************
    // code to margin
    threshold_margin margin_map (
        .code(threshold_r),
        .margin_mv(margin_mv)
    );

    always_ff @(posedge CLK) begin
        if (RST) begin
            margin_r <= MARGIN_CODE2_MV;
        end else begin
            margin_r <= margin_mv;
        end
    end

    assign REG_RDATA = rdata_r;
    assign REG_RVALID = rvalid_r;
    assign BIAS_OV_THRESHOLD = threshold_r;
    assign BIAS_OV_MARGIN_MV = margin_r;
endmodule // mic_input_fault_status_bank

/* verification/fault_bank_asserts.sv */
// Purpose: port checker of the fault status bank
// Assumes: two-flop detector path, read answer one cycle on
// Notes: bound below to every bank instance
`timescale 1ns/1ps
module fault_bank_asserts
    import fault_bank_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // register port
    input wire fault_bank_pkg::reg_req_t REG_REQ,
    input wire logic [7:0] REG_RDATA,
    input wire logic REG_RVALID,
    // detectors and threshold
    input wire fault_bank_pkg::ch4_fault_t CH4_FAULT,
    input wire fault_bank_pkg::input_ov_t INPUT_OV_FAULT,
    input wire fault_bank_pkg::bias_fault_t BIAS_FAULT,
    input wire logic [2:0] BIAS_OV_THRESHOLD,
    input wire logic [7:0] BIAS_OV_MARGIN_MV
);
    // ****
    // properties
    // ****
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    wire logic rd31 = REG_REQ.rd && REG_REQ.addr == CHANNEL4_FAULT_LIVE_ADDR;
    wire logic rd35 = REG_REQ.rd && REG_REQ.addr == INPUT_OVERVOLTAGE_LIVE_ADDR;
    wire logic rd37 = REG_REQ.rd && REG_REQ.addr == BIAS_FAULT_LIVE_ADDR;
    wire logic rd55 = REG_REQ.rd && REG_REQ.addr == BIAS_OVERVOLTAGE_CONFIG_ADDR;
    wire logic wr55 = REG_REQ.wr && REG_REQ.addr == BIAS_OVERVOLTAGE_CONFIG_ADDR;
    function automatic logic [7:0] mv(input logic [2:0] c);
        return c == 3'h0 ? 8'h00 : c == 3'h1 ? 8'h0a : c == 3'h7 ? 8'hbe : 8'h28 + 8'h1e * ({5'h00, c} - 8'h02);
    endfunction
    chk_rvalid_after_read: assert property (REG_REQ.rd |=> REG_RVALID)
        else $error("read not answered");
    chk_rvalid_single: assert property (!REG_REQ.rd |=> !REG_RVALID)
        else $error("read answer longer than one cycle");
    chk_channel4_fault_live: assert property (rd31 && !$past(RST) && !$past(RST, 2) |=> REG_RDATA == $past(CH4_FAULT, 3))
        else $error("channel 4 read wrong");
    chk_ov_live: assert property (rd35 && !$past(RST) && !$past(RST, 2) |=> REG_RDATA == {$past(INPUT_OV_FAULT, 3), 4'h0})
        else $error("overvoltage read wrong");
    chk_bias_live: assert property (rd37 && !$past(RST) && !$past(RST, 2) |=> REG_RDATA == {$past(BIAS_FAULT, 3), 5'h00})
        else $error("bias fault read wrong");
    chk_cfg_read: assert property (rd55 |=> REG_RDATA == {$past(BIAS_OV_THRESHOLD), 5'h00})
        else $error("config read wrong");
    chk_thres_write: assert property (wr55 |=> BIAS_OV_THRESHOLD == $past(REG_REQ.wdata[7:5]))
        else $error("threshold not written");
    chk_thres_hold: assert property (!wr55 |=> $stable(BIAS_OV_THRESHOLD))
        else $error("threshold changed unasked");
    chk_margin_map: assert property (BIAS_OV_MARGIN_MV == mv($past(BIAS_OV_THRESHOLD)))
        else $error("margin wrong");
    cover property (rd31 && CH4_FAULT != 8'h00);
    cover property (wr55);
    cover property (REG_REQ.rd && REG_REQ.addr == 8'h40);
endmodule // fault_bank_asserts

bind mic_input_fault_status_bank fault_bank_asserts u_chk (.CLK(CLK), .RST(RST), .REG_REQ(REG_REQ),
    .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .CH4_FAULT(CH4_FAULT), .INPUT_OV_FAULT(INPUT_OV_FAULT),
    .BIAS_FAULT(BIAS_FAULT), .BIAS_OV_THRESHOLD(BIAS_OV_THRESHOLD), .BIAS_OV_MARGIN_MV(BIAS_OV_MARGIN_MV));

/* verification/tb_mic_input_fault_status_bank.sv */
// Purpose: self-checking bench of the fault status bank
// Assumes: detector levels reach the read mux in two clocks
// Notes: stimulus on rising CLK by non-blocking assignment
`timescale 1ns/1ps
module tb_mic_input_fault_status_bank;
    import fault_bank_pkg::*;
    // ****
    // bench
    // ****
    logic CLK = 1'b0;
    logic RST = 1'b1;
    reg_req_t req = '0;
    ch4_fault_t ch4 = '0;
    input_ov_t ov = '0;
    bias_fault_t bias = '0;
    logic [7:0] rdata;
    logic rvalid;
    logic [2:0] thres;
    logic [7:0] margin;
    int fails = 0;
    int checked = 0;
    int cycles = 0;
    always #5 CLK = ~CLK;
    mic_input_fault_status_bank DUT (.CLK(CLK), .RST(RST), .REG_REQ(req), .REG_RDATA(rdata), .REG_RVALID(rvalid),
        .CH4_FAULT(ch4), .INPUT_OV_FAULT(ov), .BIAS_FAULT(bias), .BIAS_OV_THRESHOLD(thres), .BIAS_OV_MARGIN_MV(margin));
    task automatic conclude;
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge CLK);
        req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge CLK);
        req.rd <= 1'b0;
        #1;
        check({7'h00, rvalid}, 8'h01);
        check(rdata, exp);
        @(posedge CLK);
        #1;
        check({7'h00, rvalid}, 8'h00);
        check(rdata, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge CLK);
        req.wr <= 1'b0;
    endtask
    task automatic t_reset;
        check({5'h00, thres}, {5'h00, THRESHOLD_RESET});
        check(margin, MARGIN_CODE2_MV);
        rd(CHANNEL4_FAULT_LIVE_ADDR, LIVE_RESET);
        rd(INPUT_OVERVOLTAGE_LIVE_ADDR, LIVE_RESET);
        rd(BIAS_FAULT_LIVE_ADDR, LIVE_RESET);
        rd(BIAS_OVERVOLTAGE_CONFIG_ADDR, BIAS_OVERVOLTAGE_CONFIG_RESET);
    endtask
    task automatic t_ch4;
        for (int i = 0; i < 9; i++) begin
            @(posedge CLK);
            ch4 <= ch4_fault_t'(8'h80 >> i);
            repeat (2) @(posedge CLK);
            rd(CHANNEL4_FAULT_LIVE_ADDR, (i < 8) ? 8'h80 >> i : 8'h00);
        end
    endtask
    task automatic t_ov_bias;
        for (int i = 0; i < 6; i++) begin
            @(posedge CLK);
            ov <= (i < 5) ? input_ov_t'(4'h8 >> i) : 4'hf;
            bias <= (i < 5) ? bias_fault_t'(3'h4 >> i) : 3'h7;
            repeat (2) @(posedge CLK);
            rd(INPUT_OVERVOLTAGE_LIVE_ADDR, (i < 4) ? 8'h80 >> i : (i < 5) ? 8'h00 : 8'hf0);
            rd(BIAS_FAULT_LIVE_ADDR, (i < 3) ? 8'h80 >> i : (i < 5) ? 8'h00 : 8'he0);
        end
    endtask
    task automatic t_ro;
        wr(CHANNEL4_FAULT_LIVE_ADDR, 8'hff);
        wr(INPUT_OVERVOLTAGE_LIVE_ADDR, 8'h00);
        wr(BIAS_FAULT_LIVE_ADDR, 8'h00);
        check({5'h00, thres}, {5'h00, THRESHOLD_RESET});
        rd(CHANNEL4_FAULT_LIVE_ADDR, 8'h00);
        rd(INPUT_OVERVOLTAGE_LIVE_ADDR, 8'hf0);
        rd(BIAS_FAULT_LIVE_ADDR, 8'he0);
        rd(8'h40, UNMAPPED_READ);
    endtask
    task automatic t_codes;
        logic [7:0] mv;
        for (int c = 0; c < 8; c++) begin
            mv = (c == 0) ? MARGIN_CODE0_MV : (c == 1) ? MARGIN_CODE1_MV : (c == 7) ? MARGIN_CODE7_MV
                : MARGIN_CODE2_MV + MARGIN_STEP_MV * 8'(c - 2);
            wr(BIAS_OVERVOLTAGE_CONFIG_ADDR, {3'(c), 5'h00});
            @(posedge CLK);
            #1;
            check({5'h00, thres}, 8'(c));
            check(margin, mv);
            rd(BIAS_OVERVOLTAGE_CONFIG_ADDR, {3'(c), 5'h00});
        end
    endtask
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            conclude();
        end
    end
    initial begin
        repeat (8) @(posedge CLK);
        RST <= 1'b0;
        #1;
        t_reset();
        t_ch4();
        t_ov_bias();
        t_ro();
        t_codes();
        conclude();
    end
endmodule // tb_mic_input_fault_status_bank
